// ### design/dma_addr_consts.vh
`ifndef DMA_ADDR_CONSTS_VH
`define DMA_ADDR_CONSTS_VH

// ****************************************************************
// Register offsets, byte addresses as printed
// ****************************************************************
`define OFS_PLAY_BASE_LOW 32'h0b000028
`define OFS_PLAY_BASE_HIGH 32'h0b00002a
`define OFS_PLAY_PTR_LOW 32'h0b00002c
`define OFS_PLAY_PTR_HIGH 32'h0b00002e
`define OFS_IR_BASE_LOW 32'h0b000030
`define OFS_IR_BASE_HIGH 32'h0b000032

// ****************************************************************
// Reset values, same for every reset source
// ****************************************************************
`define RST_LOW_HALF 16'hf800
`define RST_HIGH_HALF 16'h01ff

// ****************************************************************
// Writable bit masks of the halves
// ****************************************************************
`define WMASK_FULL 16'hffff
`define WMASK_BIT0_FIXED 16'hfffe
`define WMASK_HIGH 16'h03ff

// ****************************************************************
// Buffer geometry and pointer step
// ****************************************************************
`define ORIGIN_MASK 32'hfffffc00
`define BUF_BYTES 32'h00000800
`define PTR_STEP 32'h00000002

`endif

// ### design/addr_half_reg.v
`include "dma_addr_consts.vh"

// ****************************************************************
// One 16-bit half of an address register
// ****************************************************************
module addr_half_reg #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] WMASK = 16'hffff
) (
  input wire core_clk,
  input wire nrst,
  input wire sw_wr,
  input wire [15:0] sw_data,
  input wire hw_ld,
  input wire [15:0] hw_data,
  output reg [15:0] half_q
);

  // Software write beats a hardware load in the same cycle;
  // read-only bits never leave their reset value of zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= RESET_VAL;
    end else if (sw_wr) begin
      half_q <= sw_data & WMASK;
    end else if (hw_ld) begin
      half_q <= hw_data & WMASK;
    end
  end

endmodule

// ### design/fixed_prio_arb.v
// ****************************************************************
// Fixed priority channel arbiter, one grant held until done
// ****************************************************************
module fixed_prio_arb (
  input wire core_clk,
  input wire nrst,
  input wire [2:0] req,
  input wire done,
  output reg [2:0] grant_q
);

  localparam IDLE = 1'b0;
  localparam BUSY = 1'b1;

  reg state_q;
  reg state_d;
  reg [2:0] grant_d;

  // Bit 2 beats bit 1 beats bit 0; order is fixed in hardware
  always @* begin
    state_d = state_q;
    grant_d = grant_q;
    case (state_q)
      IDLE: begin
        if (req[2]) begin
          grant_d = 3'h4;
          state_d = BUSY;
        end else if (req[1]) begin
          grant_d = 3'h2;
          state_d = BUSY;
        end else if (req[0]) begin
          grant_d = 3'h1;
          state_d = BUSY;
        end
      end
      BUSY: begin
        if (done) begin
          grant_d = 3'h0;
          state_d = IDLE;
        end
      end
      default: begin
        grant_d = 3'h0;
        state_d = IDLE;
      end
    endcase
  end

  // State and grant flops
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IDLE;
      grant_q <= 3'h0;
    end else begin
      state_q <= state_d;
      grant_q <= grant_d;
    end
  end

endmodule

// ### design/dma_address_unit.v
// Functional notes
// - Playback base bits 31..26 read zero and ignore writes.
// - Playback base high half bits 9..0 hold base bits 25..16, r/w.
// - The playback base is the playback channel's start address.
// - Playback buffer is 2 Kbyte at the base with low 10 bits cleared.
// - Playback pointer low half holds next address bits 15..0, r/w.
// - Playback pointer high half: bits 31..26 zero, 25..16 writable.
// - Infrared base low half holds bits 15..0, all sixteen r/w.
// - Infrared base bits 31..26 read zero, bits 25..16 writable.
// - The infrared base is the infrared channel's start address.
// - Infrared buffer is 2 Kbyte at the base with low 10 bits cleared.
// - Playback base bit 0 always reads zero and ignores writes.
// - Colliding requests go recording, then playback, then infrared.

`include "dma_addr_consts.vh"

module dma_address_unit (
  core_clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rec_req,
  play_req,
  ir_req,
  xfer_done,
  rec_grant,
  play_grant,
  ir_grant,
  play_addr,
  play_origin,
  ir_start,
  ir_origin
);

  input wire core_clk;
  input wire nrst;
  input wire [31:0] reg_addr;
  input wire [15:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [15:0] reg_rdata;
  input wire rec_req;
  input wire play_req;
  input wire ir_req;
  input wire xfer_done;
  output wire rec_grant;
  output wire play_grant;
  output wire ir_grant;
  output reg [31:0] play_addr;
  output reg [31:0] play_origin;
  output reg [31:0] ir_start;
  output reg [31:0] ir_origin;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  wire sel_pbl;
  wire sel_pbh;
  wire sel_ppl;
  wire sel_pph;
  wire sel_ibl;
  wire sel_ibh;

  // Full 32-bit compare, so aliases never hit a register
  assign sel_pbl = (reg_addr == `OFS_PLAY_BASE_LOW);
  assign sel_pbh = (reg_addr == `OFS_PLAY_BASE_HIGH);
  assign sel_ppl = (reg_addr == `OFS_PLAY_PTR_LOW);
  assign sel_pph = (reg_addr == `OFS_PLAY_PTR_HIGH);
  assign sel_ibl = (reg_addr == `OFS_IR_BASE_LOW);
  assign sel_ibh = (reg_addr == `OFS_IR_BASE_HIGH);

  // ****************************************************************
  // Register halves
  // ****************************************************************

  wire [15:0] pb_lo;
  wire [15:0] pb_hi;
  wire [15:0] pp_lo;
  wire [15:0] pp_hi;
  wire [15:0] ib_lo;
  wire [15:0] ib_hi;
  wire ptr_ld;
  wire [31:0] ptr_ld_val;

  addr_half_reg #(
    .RESET_VAL(`RST_LOW_HALF),
    .WMASK(`WMASK_BIT0_FIXED)
  ) u_pb_lo (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_pbl),
    .sw_data(reg_wdata),
    .hw_ld(1'b0),
    .hw_data(16'h0000),
    .half_q(pb_lo)
  );

  addr_half_reg #(
    .RESET_VAL(`RST_HIGH_HALF),
    .WMASK(`WMASK_HIGH)
  ) u_pb_hi (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_pbh),
    .sw_data(reg_wdata),
    .hw_ld(1'b0),
    .hw_data(16'h0000),
    .half_q(pb_hi)
  );

  addr_half_reg #(
    .RESET_VAL(`RST_LOW_HALF),
    .WMASK(`WMASK_FULL)
  ) u_pp_lo (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_ppl),
    .sw_data(reg_wdata),
    .hw_ld(ptr_ld),
    .hw_data(ptr_ld_val[15:0]),
    .half_q(pp_lo)
  );

  addr_half_reg #(
    .RESET_VAL(`RST_HIGH_HALF),
    .WMASK(`WMASK_HIGH)
  ) u_pp_hi (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_pph),
    .sw_data(reg_wdata),
    .hw_ld(ptr_ld),
    .hw_data(ptr_ld_val[31:16]),
    .half_q(pp_hi)
  );

  addr_half_reg #(
    .RESET_VAL(`RST_LOW_HALF),
    .WMASK(`WMASK_FULL)
  ) u_ib_lo (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_ibl),
    .sw_data(reg_wdata),
    .hw_ld(1'b0),
    .hw_data(16'h0000),
    .half_q(ib_lo)
  );

  addr_half_reg #(
    .RESET_VAL(`RST_HIGH_HALF),
    .WMASK(`WMASK_HIGH)
  ) u_ib_hi (
    .core_clk(core_clk),
    .nrst(nrst),
    .sw_wr(reg_wr & sel_ibh),
    .sw_data(reg_wdata),
    .hw_ld(1'b0),
    .hw_data(16'h0000),
    .half_q(ib_hi)
  );

  // ****************************************************************
  // Joined addresses and buffer windows
  // ****************************************************************

  wire [31:0] pb_full;
  wire [31:0] pp_full;
  wire [31:0] ib_full;
  wire [31:0] pb_origin;
  wire [31:0] ib_origin;
  wire [31:0] pb_end;
  wire [31:0] pp_step;

  assign pb_full = {pb_hi, pb_lo};
  assign pp_full = {pp_hi, pp_lo};
  assign ib_full = {ib_hi, ib_lo};

  assign pb_origin = pb_full & `ORIGIN_MASK;
  assign pb_end = pb_origin + `BUF_BYTES;
  assign ib_origin = ib_full & `ORIGIN_MASK;

  // ****************************************************************
  // Playback pointer walk
  // ****************************************************************

  // A base write restarts the walk at the new start address, so
  // software need not reprogram the pointer by hand
  reg base_wr_q;
  wire play_done;

  assign play_done = xfer_done & play_grant;
  assign pp_step = pp_full + `PTR_STEP;

  // Base write seen one cycle late so both halves are settled
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      base_wr_q <= 1'b0;
    end else begin
      base_wr_q <= reg_wr & (sel_pbl | sel_pbh);
    end
  end

  assign ptr_ld = base_wr_q | play_done;
  assign ptr_ld_val = base_wr_q ? pb_full :
                      (pp_step >= pb_end) ? pb_origin : pp_step;

  // ****************************************************************
  // Channel arbitration
  // ****************************************************************

  wire [2:0] grants;

  fixed_prio_arb u_arb (
    .core_clk(core_clk),
    .nrst(nrst),
    .req({rec_req, play_req, ir_req}),
    .done(xfer_done),
    .grant_q(grants)
  );

  // Grants come straight from the arbiter flops
  assign rec_grant = grants[2];
  assign play_grant = grants[1];
  assign ir_grant = grants[0];

  // ****************************************************************
  // Address outputs to the DMA logic
  // ****************************************************************

  // Registered so the bus side sees clean, glitch-free addresses;
  // costs one cycle of lag after any register change
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      play_addr <= 32'h00000000;
      play_origin <= 32'h00000000;
      ir_start <= 32'h00000000;
      ir_origin <= 32'h00000000;
    end else begin
      play_addr <= pp_full;
      play_origin <= pb_origin;
      ir_start <= ib_full;
      ir_origin <= ib_origin;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  reg [15:0] rd_mux;

  // Unmapped offsets read zero
  always @* begin
    rd_mux = 16'h0000;
    if (sel_pbl) begin
      rd_mux = pb_lo;
    end else if (sel_pbh) begin
      rd_mux = pb_hi;
    end else if (sel_ppl) begin
      rd_mux = pp_lo;
    end else if (sel_pph) begin
      rd_mux = pp_hi;
    end else if (sel_ibl) begin
      rd_mux = ib_lo;
    end else if (sel_ibh) begin
      rd_mux = ib_hi;
    end
  end

  // Data valid only in the cycle after the strobe, zero otherwise
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ### tb/dma_address_unit_props.sv
// **********
// Port checker
// **********
module dma_address_unit_props (
  input logic core_clk,
  input logic nrst,
  input logic [31:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic rec_req,
  input logic play_req,
  input logic ir_req,
  input logic xfer_done,
  input logic rec_grant,
  input logic play_grant,
  input logic ir_grant,
  input logic [31:0] play_addr,
  input logic [31:0] play_origin,
  input logic [31:0] ir_start,
  input logic [31:0] ir_origin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Grants gathered, recording first
  wire [2:0] g = {rec_grant, play_grant, ir_grant};

  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside a read");
  hi_fixed_zero_a: assert property (reg_rd && reg_addr[1]
    |=> reg_rdata[15:10] == 6'h0) else $error("upper bits not zero");
  base_bit0_a: assert property (reg_rd && reg_addr == 32'h0b000028
    |=> !reg_rdata[0]) else $error("base bit 0 not zero");
  addr_top_a: assert property (play_addr[31:26] == 6'h0
    && ir_start[31:26] == 6'h0) else $error("address top bits set");
  // Both flops load in the same cycle, so they always agree
  ir_origin_a: assert property (ir_origin ==
    (ir_start & 32'hfffffc00)) else $error("infrared origin wrong");
  // Playback window always starts on a cleared low field
  play_origin_a: assert property (play_origin[9:0] == 10'h0
    && play_origin[31:26] == 6'h0) else $error("playback origin wrong");
  base_load_a: assert property (reg_wr && reg_addr == 32'h0b00002a
    |=> ##2 play_addr[25:16] == $past(reg_wdata[9:0], 3))
    else $error("base not loaded into pointer");
  ptr_step_a: assert property (play_grant && xfer_done && !reg_wr
    |=> ##1 (play_addr == $past(play_addr, 2) + 32'h2
    || play_addr == play_origin)) else $error("pointer did not step");
  grant_one_a: assert property ($onehot0(g))
    else $error("more than one grant");
  grant_drop_a: assert property ((|g) && xfer_done |=> g == 3'h0)
    else $error("grant held after done");
  rec_first_a: assert property (g == 3'h0 && rec_req |=> rec_grant)
    else $error("recording not served first");
  play_next_a: assert property (g == 3'h0 && !rec_req && play_req
    |=> play_grant) else $error("playback not before infrared");
  ir_last_a: assert property (g == 3'h0 && !rec_req && !play_req
    && ir_req |=> ir_grant) else $error("infrared not served last");
endmodule

bind dma_address_unit dma_address_unit_props dma_address_unit_props_inst (
  .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rec_req, .play_req, .ir_req, .xfer_done, .rec_grant, .play_grant,
  .ir_grant, .play_addr, .play_origin, .ir_start, .ir_origin
);

// ### tb/dma_ctrl_model.sv
// **********
// DMA control side model
// **********
module dma_ctrl_model (
  input logic core_clk,
  input logic nrst,
  input logic [2:0] post,
  input logic [3:0] lat,
  input logic [2:0] grant,
  output logic [2:0] req,
  output logic xfer_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // Requests stay up until served; done after lat+1 cycles of grant
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req <= 3'h0;
      cnt_q <= 4'h0;
      xfer_done <= 1'b0;
    end else begin
      req <= (req | post) & ~(grant & {3{xfer_done}});
      if (grant == 3'h0) begin
        cnt_q <= 4'h0;
        xfer_done <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
        xfer_done <= (cnt_q == lat); // Overrun count keeps it one pulse
      end
    end
  end
endmodule

// ### tb/dma_address_unit_test.sv
// **********
// Testbench
// **********
module dma_address_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] post = 3'h0;
  logic [3:0] lat = 4'h0;
  wire [15:0] reg_rdata;
  wire [2:0] req;
  wire xfer_done, rec_grant, play_grant, ir_grant;
  wire [31:0] play_addr, play_origin, ir_start, ir_origin;
  wire [2:0] g = {rec_grant, play_grant, ir_grant};
  int error_cnt = 0;
  int checked = 0;
  int i;
  // Address byte, written data, data read back; last row unmapped
  logic [39:0] rows [7] = '{40'h28_ffff_fffe, 40'h2a_ffff_03ff,
    40'h2c_ffff_ffff, 40'h2e_ffff_03ff, 40'h30_ffff_ffff,
    40'h32_ffff_03ff, 40'h40_ffff_0000};

  dma_address_unit dma_address_unit_inst (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rec_req(req[2]), .play_req(req[1]),
    .ir_req(req[0]), .xfer_done(xfer_done), .rec_grant(rec_grant),
    .play_grant(play_grant), .ir_grant(ir_grant), .play_addr(play_addr),
    .play_origin(play_origin), .ir_start(ir_start), .ir_origin(ir_origin));
  dma_ctrl_model dma_ctrl_model_inst (.core_clk(core_clk), .nrst(nrst),
    .post(post), .lat(lat), .grant(g), .req(req), .xfer_done(xfer_done));

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles: strobe one cycle, data read in the cycle after
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= {24'h0b0000, a};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= {24'h0b0000, a};
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait for a grant pattern
  task automatic wait_g(input logic [2:0] e);
    int n;
    n = 0;
    while (g !== e && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk({29'h0, g}, {29'h0, e});
  endtask
  task automatic do_reset;
    logic [15:0] d;
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(play_addr, 32'h01fff800);
    chk(play_origin, 32'h01fff800);
    chk(ir_start, 32'h01fff800);
    chk(ir_origin, 32'h01fff800);
    for (int k = 0; k < 6; k++) begin
      rd(rows[k][39:32], d);
      chk({16'h0, d}, rows[k][33] ? 32'h01ff : 32'hf800);
    end
    $display("reset test done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [15:0] d;
    do_reset();
    for (i = 0; i < 7; i++) begin
      wr(rows[i][39:32], rows[i][31:16]);
      rd(rows[i][39:32], d);
      chk({16'h0, d}, {16'h0, rows[i][15:0]});
    end
    $display("register table done");
    wr(8'h2a, 16'h0012);
    wr(8'h28, 16'h0ffc);
    repeat (3) @(posedge core_clk);
    #1 chk(play_addr, 32'h00120ffc);
    chk(play_origin, 32'h00120c00);
    // Pointer two steps short of the buffer end
    wr(8'h2c, 16'h13fc);
    repeat (2) @(posedge core_clk);
    #1 chk(play_addr, 32'h001213fc);
    lat <= 4'h5;
    post <= 3'b111;
    @(posedge core_clk);
    post <= 3'b000;
    wait_g(3'b100);
    wait_g(3'b010);
    wait_g(3'b001);
    wait_g(3'b000);
    chk(play_addr, 32'h001213fe);
    lat <= 4'h0;
    post <= 3'b010;
    @(posedge core_clk);
    post <= 3'b000;
    wait_g(3'b010);
    wait_g(3'b000);
    repeat (2) @(posedge core_clk);
    #1 chk(play_addr, 32'h00120c00);
    $display("arbitration and wrap done");
    wr(8'h32, 16'h0123);
    wr(8'h30, 16'h0456);
    repeat (2) @(posedge core_clk);
    #1 chk(ir_start, 32'h01230456);
    chk(ir_origin, 32'h01230400);
    $display("infrared base done");
    do_reset();
    results();
  end

  // Whole run is well under 1000 cycles
  initial begin
    #80000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
